/* File: io_ports_pkg.sv */
/*
 Package for the multiplexed open-drain I/O port block: reset values,
 widths, pin indices and the packed structs used as carriers.
 Assumes a single core clock and an active-low asynchronous reset.
*/
package io_ports_pkg;

    localparam int BIT_W = 6;
    localparam int NIB_W = 4;
    localparam int PAIR_W = 2;
    localparam int PIN_W = 18;

    localparam logic [BIT_W-1:0] BIT_LATCH_RST = 6'h3F;
    localparam logic [NIB_W-1:0] NIB_LATCH_RST = 4'hF;
    localparam logic [PAIR_W-1:0] PAIR_LATCH_RST = 2'h3;
    localparam logic [PIN_W-1:0] ENABLE_RST = 18'h00000;
    localparam logic [3:0] IRQ_CTRL_RST = 4'h0;

    localparam int IRQ_EN_BIT = 3;
    localparam int TIMER_BIT = 2;
    localparam int IRQ_BIT = 3;
    localparam int ALIAS_C = 2;
    localparam int ALIAS_K = 3;
    localparam int SYNC_STAGES = 2;

    // Packed order of the eighteen pins, low bit first
    localparam int POS_BIT = 0;
    localparam int POS_NIB0 = 6;
    localparam int POS_NIB1 = 10;
    localparam int POS_PAIR2 = 14;

    typedef struct packed {
        logic [PAIR_W-1:0] pair_port_three;
        logic [PAIR_W-1:0] pair_port_two;
        logic [NIB_W-1:0] nibble_port_one;
        logic [NIB_W-1:0] nibble_port_zero;
        logic [BIT_W-1:0] bitwise_port_pins;
    } port_pins_t;

    // Latch write command from the CPU side
    typedef struct packed {
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_idx;
        logic nib0_wr;
        logic nib1_wr;
        logic pair2_wr;
        logic pair3_wr;
        logic [3:0] data;
    } port_write_t;

    typedef enum logic [1:0] {
        TIO_OFF = 2'b00,
        TIO_IN = 2'b01,
        TIO_OUT_T1 = 2'b10,
        TIO_OUT_T2 = 2'b11
    } timer_io_mode_t;

endpackage

/* File: pin_sync.sv */
/*
 Two-flop synchroniser bank for the port pin inputs.
 Assumes the pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import io_ports_pkg::*;
#(
    parameter int WIDTH = PIN_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // Pins idle high when released, so both stages reset high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '1;
            sync_out <= '1;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: io_ports.sv */
/*
 Multiplexed open-drain I/O ports: output latches, pull-up and wakeup
 enables, skip test, timer pin toggling, irq pin gating, reset pin.
 Assumes CPU commands are single-cycle strobes on core_clk and that pads
 are open-drain: pin_oe_n low means the pad pulls the line to 0.
*/
`timescale 1ns/1ps
`default_nettype none
module io_ports
    import io_ports_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire port_write_t port_wr,
    input wire logic [2:0] skip_idx,
    input wire logic [PIN_W-1:0] pullup_en_wr_data,
    input wire logic pullup_en_wr,
    input wire logic [PIN_W-1:0] wakeup_en_wr_data,
    input wire logic wakeup_en_wr,
    input wire logic [3:0] irq_ctrl_wr_data,
    input wire logic irq_ctrl_wr,
    input wire timer_io_mode_t timer_io_mode,
    input wire logic timer1_underflow,
    input wire logic timer2_underflow,
    input wire logic watchdog_timeout,
    input wire logic power_on_reset,
    input wire logic backup_active,
    input wire logic [PIN_W-1:0] pin_in,
    output logic [PIN_W-1:0] pin_out,
    output logic [PIN_W-1:0] pin_oe_n,
    output logic [PIN_W-1:0] pullup_on,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic skip_cond,
    output port_pins_t port_read,
    output logic [3:0] analog_input_pins,
    output logic timer2_ext_clk,
    output logic irq_request,
    output logic wakeup_req,
    output logic [3:0] irq_pin_control_reg
);
    logic [BIT_W-1:0] bit_latch_r;
    logic [NIB_W-1:0] nib0_latch_r;
    logic [NIB_W-1:0] nib1_latch_r;
    logic [PAIR_W-1:0] pair2_latch_r;
    logic [PAIR_W-1:0] pair3_latch_r;
    port_pins_t latch_all;
    port_pins_t pin_sync_w;
    logic [PIN_W-1:0] pullup_en_r;
    logic [PIN_W-1:0] wakeup_en_r;
    logic timer_io_r;
    logic [PIN_W-1:0] drive_low;
    logic irq_pin_input_enable;
    logic [PIN_W-1:0] wake_mask;

    // Only these pins carry the pull-up and wakeup options
    localparam logic [PIN_W-1:0] OPT_MASK = 18'h0FFCC;

    function automatic logic [PIN_W-1:0] low_pins(
        input logic [PIN_W-1:0] lvl, input logic [PIN_W-1:0] mask);
        low_pins = ~lvl & mask;
    endfunction

    pin_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(pin_in),
        .sync_out(pin_sync_w)
    );

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_latch_r <= BIT_LATCH_RST;
        end else if (port_wr.bit_set && port_wr.bit_idx < 3'(BIT_W)) begin
            bit_latch_r[port_wr.bit_idx] <= 1'b1;
        end else if (port_wr.bit_clr && port_wr.bit_idx < 3'(BIT_W)) begin
            bit_latch_r[port_wr.bit_idx] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nib0_latch_r <= NIB_LATCH_RST;
            nib1_latch_r <= NIB_LATCH_RST;
        end else begin
            if (port_wr.nib0_wr) begin
                nib0_latch_r <= port_wr.data;
            end
            if (port_wr.nib1_wr) begin
                nib1_latch_r <= port_wr.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pair2_latch_r <= PAIR_LATCH_RST;
            pair3_latch_r <= PAIR_LATCH_RST;
        end else begin
            if (port_wr.pair2_wr) begin
                pair2_latch_r <= port_wr.data[PAIR_W-1:0];
            end
            if (port_wr.pair3_wr) begin
                pair3_latch_r <= port_wr.data[PAIR_W-1:0];
            end
        end
    end

    // One register per port, so no two processes write one struct
    assign latch_all = {pair3_latch_r, pair2_latch_r, nib1_latch_r,
                        nib0_latch_r, bit_latch_r};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pullup_en_r <= ENABLE_RST;
            wakeup_en_r <= ENABLE_RST;
        end else begin
            if (pullup_en_wr) begin
                pullup_en_r <= pullup_en_wr_data & OPT_MASK;
            end
            if (wakeup_en_wr) begin
                wakeup_en_r <= wakeup_en_wr_data & OPT_MASK;
            end
        end
    end

    // irq control resets with input disabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_pin_control_reg <= IRQ_CTRL_RST;
        end else if (irq_ctrl_wr) begin
            irq_pin_control_reg <= irq_ctrl_wr_data;
        end
    end
    assign irq_pin_input_enable = irq_pin_control_reg[IRQ_EN_BIT];

    // toggle on chosen underflow, halving its rate
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_io_r <= 1'b1;
        end else if ((timer_io_mode == TIO_OUT_T1 && timer1_underflow) ||
                     (timer_io_mode == TIO_OUT_T2 && timer2_underflow)) begin
            timer_io_r <= ~timer_io_r;
        end
    end

    // open-drain drive; timer output ANDs with port latch
    always_comb begin
        drive_low = ~latch_all;
        if (timer_io_mode == TIO_OUT_T1 || timer_io_mode == TIO_OUT_T2) begin
            drive_low[POS_NIB1+TIMER_BIT] = ~(nib1_latch_r[TIMER_BIT] & timer_io_r);
        end
    end

    // Driven value is always 0; only the enable moves
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_oe_n <= '1;
            pin_out <= '0;
            pullup_on <= '0;
        end else begin
            pin_oe_n <= ~drive_low;
            pin_out <= '0;
            pullup_on <= pullup_en_r & ~drive_low;
        end
    end

    // reads see the pin even if shared
    assign port_read = pin_sync_w;
    assign analog_input_pins = {pair3_latch_r, pair2_latch_r};

    // skip when tested pin reads low
    always_comb begin
        skip_cond = 1'b0;
        if (skip_idx < 3'(BIT_W)) begin
            skip_cond = ~pin_sync_w.bitwise_port_pins[skip_idx];
        end
    end

    assign timer2_ext_clk = (timer_io_mode == TIO_IN) &&
                            pin_sync_w.nibble_port_one[TIMER_BIT];

    assign irq_request = irq_pin_input_enable &&
                         pin_sync_w.nibble_port_one[IRQ_BIT];

    // any enabled low pin wakes from back-up
    always_comb begin
        wake_mask = low_pins(pin_sync_w, wakeup_en_r);
    end
    assign wakeup_req = backup_active && (|wake_mask);

    // reset pin pulled low by watchdog or power-on
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_pin_oe_n <= 1'b0;
        end else begin
            reset_pin_oe_n <= ~(watchdog_timeout | power_on_reset);
        end
    end
    assign reset_pin_out = 1'b0;

    // Latch reset is all ones so pins float after reset
    release_after_reset_a:
    assert property (@(posedge core_clk)
        $rose(reset_n) |-> pin_oe_n == '1)
        else $error("pins driven right after reset");

    open_drain_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        port_wr.nib0_wr && port_wr.data == 4'h0 && timer_io_mode == TIO_OFF
        |-> ##2 pin_oe_n[POS_NIB0+:NIB_W] == 4'h0)
        else $error("nibble zero not pulled low");

    irq_gate_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        !irq_pin_control_reg[IRQ_EN_BIT] |-> !irq_request)
        else $error("irq passed while disabled");

    timer_toggle_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        timer_io_mode == TIO_OUT_T1 && timer1_underflow
        |=> timer_io_r != $past(timer_io_r))
        else $error("timer pin did not toggle");

    reset_pin_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        watchdog_timeout |=> !reset_pin_oe_n)
        else $error("reset pin not driven");

    pullup_off_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        pullup_on[POS_PAIR2+PAIR_W+:PAIR_W] == 2'h0)
        else $error("pair three pull-up on");

    skip_map_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        skip_idx == 3'h0 |-> skip_cond == !port_read.bitwise_port_pins[0])
        else $error("skip does not follow pin");

    wake_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        backup_active && wakeup_en_r[POS_NIB0] &&
        !port_read.nibble_port_zero[0] |-> wakeup_req)
        else $error("no wakeup from enabled pin");

    bit_set_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        port_wr.bit_set && port_wr.bit_idx < 3'(BIT_W)
        |=> bit_latch_r[$past(port_wr.bit_idx)])
        else $error("bitwise latch not set");

    bit_clear_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        port_wr.bit_clr && !port_wr.bit_set && port_wr.bit_idx < 3'(BIT_W)
        |=> !bit_latch_r[$past(port_wr.bit_idx)])
        else $error("bitwise latch not cleared");

    bit_refuse_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        (port_wr.bit_set || port_wr.bit_clr) && port_wr.bit_idx >= 3'(BIT_W)
        |=> $stable(bit_latch_r))
        else $error("bad bit index changed latch");

    nib1_write_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        port_wr.nib1_wr |=> nib1_latch_r == $past(port_wr.data))
        else $error("nibble one latch not loaded");

    pair3_write_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        port_wr.pair3_wr |=> pair3_latch_r == $past(port_wr.data[PAIR_W-1:0]))
        else $error("pair three latch not loaded");

    pair3_wake_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        wakeup_en_r[POS_PAIR2+PAIR_W+:PAIR_W] == 2'h0)
        else $error("pair three wakeup on");

    por_drive_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        power_on_reset |=> !reset_pin_oe_n)
        else $error("reset pin not driven on power-on");

    timer2_toggle_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        timer_io_mode == TIO_OUT_T2 && timer2_underflow
        |=> timer_io_r != $past(timer_io_r))
        else $error("timer pin ignored second timer");

    pullup_driven_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        (pullup_on & ~pin_oe_n) == '0)
        else $error("pull-up on a driven pin");

    wake_idle_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        !backup_active |-> !wakeup_req)
        else $error("wakeup outside back-up");

    tio_clk_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        timer_io_mode != TIO_IN |-> !timer2_ext_clk)
        else $error("counter clock while not input");
endmodule
`default_nettype wire

/* File: board_model.sv */
/*
 Board model: open-drain lines with keys and board resistors.
 Assumes pin_oe_n low means the device sinks the line.
*/
`timescale 1ns/1ps
`default_nettype none
// Board resistors hold up the pins that have no internal pull-up
module board_model #(
    parameter logic [17:0] EXT_PU = 18'h30033
) (
    input wire logic core_clk,
    input wire logic [17:0] pin_oe_n,
    input wire logic [17:0] pullup_on,
    input wire logic [17:0] key_low,
    output logic [17:0] pin_in
);
    logic flt_r = 1'b0;
    // Unpulled lines wander, so a stale level never reads as valid
    always @(posedge core_clk) begin
        flt_r <= ~flt_r;
    end
    assign pin_in = pin_oe_n & ~key_low & (pullup_on | EXT_PU | {18{flt_r}});
endmodule
`default_nettype wire

/* File: multiplexed_io_ports_test.sv */
/*
 Testbench for io_ports: strobed commands, board model on the pins.
 Assumes the package and board_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module multiplexed_io_ports_test;
    import io_ports_pkg::*;
    logic core_clk, reset_n, pu_w, wk_w, irq_w, t1, t2, wd, por, bk, v;
    logic [17:0] pu_d, wk_d, key, pin_in, pin_oe_n, pullup_on;
    logic [3:0] irq_d, irq_reg, ana;
    logic [2:0] skip_idx;
    logic skip_cond, reset_pin_oe_n, t2_clk, irq_req, wake;
    port_write_t wr;
    port_pins_t rd;
    timer_io_mode_t mode;
    int n_fail = 0;
    int num_checks = 0;
    logic [18:0] wk_tab [6] = '{19'h00081, 19'h00002, 19'h08001,
        19'h20000, 19'h00020, 19'h00011};
    io_ports DUT (.core_clk(core_clk), .reset_n(reset_n), .port_wr(wr),
        .skip_idx(skip_idx), .pullup_en_wr_data(pu_d),
        .pullup_en_wr(pu_w), .wakeup_en_wr_data(wk_d),
        .wakeup_en_wr(wk_w), .irq_ctrl_wr_data(irq_d),
        .irq_ctrl_wr(irq_w), .timer_io_mode(mode),
        .timer1_underflow(t1), .timer2_underflow(t2),
        .watchdog_timeout(wd), .power_on_reset(por),
        .backup_active(bk), .pin_in(pin_in), .pin_out(),
        .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .reset_pin_out(),
        .reset_pin_oe_n(reset_pin_oe_n), .skip_cond(skip_cond),
        .port_read(rd), .analog_input_pins(ana), .timer2_ext_clk(t2_clk),
        .irq_request(irq_req), .wakeup_req(wake),
        .irq_pin_control_reg(irq_reg));
    board_model board (.core_clk(core_clk), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .key_low(key), .pin_in(pin_in));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Strobe, then wait out latch, pad enable and the input synchroniser
    task automatic latch(input logic [12:0] c);
        wr = port_write_t'(c);
        tick(1);
        wr = '0;
        tick(4);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
    initial begin
        {reset_n, pu_w, wk_w, irq_w, t1, t2, wd, por, bk} = '0;
        {pu_d, wk_d, key, irq_d, skip_idx} = '0;
        wr = '0;
        mode = TIO_OFF;
        tick(10);
        `chk(pin_oe_n, 18'h3FFFF)
        `chk(pullup_on, 18'h00000)
        `chk(reset_pin_oe_n, 1'b0)
        reset_n = 1'b1;
        tick(2);
        `chk(reset_pin_oe_n, 1'b1)
        `chk(irq_reg, 4'h0)
        pu_d = '1;
        wk_d = '1;
        {pu_w, wk_w} = 2'b11;
        tick(1);
        {pu_w, wk_w} = 2'b00;
        tick(2);
        `chk(pullup_on, 18'h0FFCC)
        for (int i = 0; i < 6; i++) begin
            skip_idx = 3'(i);
            latch({2'b01, 3'(i), 8'h00});
            `chk(pin_oe_n, ~(18'h1 << i))
            `chk(skip_cond, 1'b1)
            latch({2'b10, 3'(i), 8'h00});
            `chk(skip_cond, 1'b0)
        end
        latch({2'b01, 3'd6, 8'h00});
        `chk(pin_oe_n, 18'h3FFFF)
        latch({5'h00, 4'h8, 4'h5});
        latch({5'h00, 4'h4, 4'hA});
        latch({5'h00, 4'h2, 4'h1});
        latch({5'h00, 4'h1, 4'h2});
        `chk(pin_oe_n, 18'h2697F)
        `chk(rd.pair_port_three, 2'h2)
        `chk(ana, 4'h9)
        `chk(rd.nibble_port_zero, 4'h5)
        `chk(rd.nibble_port_one, 4'hA)
        `chk(rd.pair_port_two, 2'h1)
        latch({5'h00, 4'h8, 4'h0});
        `chk(pin_oe_n[9:6], 4'h0)
        latch({5'h00, 4'hF, 4'hF});
        bk = 1'b1;
        foreach (wk_tab[k]) begin
            key = wk_tab[k][18:1];
            tick(3);
            `chk(wake, wk_tab[k][0])
        end
        bk = 1'b0;
        tick(1);
        `chk(wake, 1'b0)
        `chk(irq_req, 1'b0)
        key = 18'h02000;
        tick(3);
        `chk(irq_req, 1'b0)
        `chk(rd.nibble_port_one, 4'h7)
        irq_d = 4'h8;
        irq_w = 1'b1;
        tick(1);
        irq_w = 1'b0;
        tick(1);
        `chk(irq_reg, 4'h8)
        key = 18'h00000;
        mode = TIO_OUT_T1;
        tick(4);
        `chk(irq_req, 1'b1)
        v = pin_oe_n[12];
        for (int j = 0; j < 4; j++) begin
            mode = (j < 3) ? TIO_OUT_T1 : TIO_OUT_T2;
            {t1, t2} = (j < 2) ? 2'b10 : 2'b01;
            tick(1);
            {t1, t2} = 2'b00;
            tick(4);
            v = (j != 2) ? ~v : v;
            `chk(pin_oe_n[12], v)
            `chk(rd.nibble_port_one[2], v)
        end
        mode = TIO_IN;
        tick(4);
        key = 18'h01000;
        tick(3);
        `chk(t2_clk, 1'b0)
        key = 16'h0000;
        tick(3);
        `chk(t2_clk, 1'b1)
        for (int k = 0; k < 2; k++) begin
            {wd, por} = 2'(1 << k);
            tick(2);
            `chk(reset_pin_oe_n, 1'b0)
            {wd, por} = 2'b00;
            tick(2);
            `chk(reset_pin_oe_n, 1'b1)
        end
        stop_test();
    end
endmodule
`default_nettype wire
